// ==== rtl/dram_rank_power_down_control.v ====
/*
 * rank clock-enable power-down controller with byte-lane map and output
 * tri-state control, apb register slave.
 * assumes the dram clock arrives as a plain input sampled by I_CLK and runs
 * well below half the system clock rate.
 */
`timescale 1ns/1ps
`include "pd_ctrl_defs.vh"

module dram_rank_power_down_control (
   // clock and reset
   input  wire        I_CLK,
   input  wire        I_RST,
   // apb slave
   input  wire        I_PSEL,
   input  wire        I_PENABLE,
   input  wire        I_PWRITE,
   input  wire [11:0] I_PADDR,
   input  wire [31:0] I_PWDATA,
   output reg  [31:0] O_PRDATA,
   output reg         O_PREADY,
   output reg         O_PSLVERR,
   // dram link clock, sampled
   input  wire        I_DRAM_CLK,
   // scheduler side, one bit per rank except the shared refresh request
   input  wire [3:0]  I_TXN_ARRIVE,
   input  wire [3:0]  I_TXN_QUEUED,
   input  wire        I_REFRESH_REQ,
   input  wire [3:0]  I_PRECHARGE_DONE,
   output reg  [3:0]  O_PRECHARGE_REQ,
   output reg  [3:0]  O_CMD_OK,
   output reg  [3:0]  O_PAGES_CLOSED,
   // logical lane index to physical lane (4 bits per logical byte)
   output reg  [63:0] O_LANE_MAP,
   // rank pins
   output reg  [3:0]  O_CKE,
   output reg  [3:0]  O_CKE_OE,
   output reg  [3:0]  O_CS_PD,
   output reg  [3:0]  O_CS_OE,
   output reg  [3:0]  O_CLK_OE,
   output reg  [3:0]  O_ODT_OE,
   output reg  [3:0]  O_WCK_OE
);

   reg  [15:0] pdcfg_q;
   reg  [5:0]  ctrl_q;
   reg  [3:0]  pop_q;
   reg  [2:0]  clk_sync_q;
   reg         link_level_q;
   reg  [3:0]  txn_arrive_q;
   wire [3:0]  cke_on;
   wire [3:0]  pd_state;
   wire [3:0]  pchg_req;
   wire [3:0]  cmd_ok;
   wire [3:0]  pg_closed;
   wire        link_tick;
   wire        apb_access = I_PSEL && I_PENABLE;
   wire        locked     = ctrl_q[`CTRL_LOCK];
   wire [1:0]  tech       = ctrl_q[`CTRL_TECH_HI:`CTRL_TECH_LO];
   wire        cs_based   = (tech == `TECH_DDR5) || (tech == `TECH_LP5);
   reg  [31:0] rdata_d;
   reg         err_d;
   reg  [63:0] lane_map_d;
   reg  [3:0]  hi_z_d;
   integer     i;

   // first stage feeds only the second
   always @(posedge I_CLK) begin
      if (I_RST)
         clk_sync_q <= 3'h0;
      else
         clk_sync_q <= {clk_sync_q[1:0], I_DRAM_CLK};
   end
   // a level counts only once stages two and three agree, so one glitchy
   // sample cannot make a false dram edge
   always @(posedge I_CLK) begin
      if (I_RST)
         link_level_q <= 1'b0;
      else if (clk_sync_q[1] == clk_sync_q[2])
         link_level_q <= clk_sync_q[2];
   end
   assign link_tick = clk_sync_q[1] && clk_sync_q[2] && !link_level_q;

   always @(posedge I_CLK) begin
      if (I_RST)
         txn_arrive_q <= 4'h0;
      else
         txn_arrive_q <= I_TXN_ARRIVE;
   end

   genvar g;
   generate
      for (g = 0; g < `NUM_RANKS; g = g + 1) begin : g_rank
         rank_pd_fsm u_rank (
            .clk            (I_CLK),
            .rst            (I_RST),
            .cke_release    (ctrl_q[`CTRL_CKE_RELEASE]),
            .pd_type        (pdcfg_q[`PDCFG_TYPE_HI:`PDCFG_TYPE_LO]),
            .idle_timeout   (pdcfg_q[`PDCFG_IDLE_HI:`PDCFG_IDLE_LO]),
            .link_tick      (link_tick),
            .txn_arrive     (I_TXN_ARRIVE[g]),
            .txn_queued     (I_TXN_QUEUED[g]),
            .refresh_req    (I_REFRESH_REQ),
            .precharge_done (I_PRECHARGE_DONE[g]),
            .cke_on         (cke_on[g]),
            .powered_down   (pd_state[g]),
            .precharge_req  (pchg_req[g]),
            .cmd_ok         (cmd_ok[g]),
            .pages_closed   (pg_closed[g])
         );
      end
   endgenerate

   // apb decode, zero wait state
   always @* begin
      rdata_d = 32'h0000_0000;
      err_d   = 1'b0;
      if (I_PADDR == `ADDR_PDCFG)
         rdata_d = {16'h0000, pdcfg_q};
      else if (I_PADDR == `ADDR_CTRL)
         rdata_d = {26'h0000000, ctrl_q};
      else if (I_PADDR == `ADDR_POP)
         rdata_d = {28'h0000000, pop_q};
      else if (I_PADDR == `ADDR_STATUS)
         rdata_d = {16'h0000, pg_closed, cmd_ok, pd_state, cke_on};
      else if (I_PADDR == `ADDR_LANEMAP)
         rdata_d = {31'h00000000, ctrl_q[`CTRL_INTERLEAVE]};
      else
         err_d = 1'b1;
   end

   always @(posedge I_CLK) begin
      if (I_RST) begin
         pdcfg_q   <= `PDCFG_RESET;
         ctrl_q    <= 6'h00;
         pop_q     <= 4'hF;
         O_PRDATA  <= 32'h0000_0000;
         O_PREADY  <= 1'b0;
         O_PSLVERR <= 1'b0;
      end else begin
         O_PREADY  <= I_PSEL && !I_PENABLE;
         O_PSLVERR <= 1'b0;
         if (I_PSEL && !I_PENABLE) begin
            O_PRDATA  <= rdata_d;
            O_PSLVERR <= err_d;
         end
         if (apb_access && O_PREADY && I_PWRITE && !err_d) begin
            // lock freezes power-down config; lane mode kept by firmware pre-training
            if (I_PADDR == `ADDR_PDCFG && !locked)
               pdcfg_q <= I_PWDATA[15:0];
            else if (I_PADDR == `ADDR_CTRL)
               ctrl_q <= {I_PWDATA[5:2], I_PWDATA[1] | locked, I_PWDATA[0]};
            else if (I_PADDR == `ADDR_POP)
               pop_q <= I_PWDATA[3:0];
            else if (I_PADDR == `ADDR_LANEMAP)
               ctrl_q[`CTRL_INTERLEAVE] <= I_PWDATA[0];
         end
      end
   end

   // lane map: ddr4 interleaved sends lane pairs 0-3 to even physical pairs, 4-7 to odd; others follow the straight table
   always @* begin
      lane_map_d = 64'h0;
      for (i = 0; i < 16; i = i + 1)
         lane_map_d[i*4 +: 4] = i[3:0];
      if (tech == `TECH_DDR4 && ctrl_q[`CTRL_INTERLEAVE]) begin
         lane_map_d[15:0]  = 16'h5410;
         lane_map_d[31:16] = 16'hDC98;
         lane_map_d[47:32] = 16'h7632;
         lane_map_d[63:48] = 16'hFEBA;
      end
   end

   // ranks proven absent go high impedance once firmware allows it
   always @* begin
      hi_z_d = ~pop_q & {4{ctrl_q[`CTRL_TRISTATE_EN]}};
   end

   always @(posedge I_CLK) begin
      if (I_RST) begin
         O_CKE           <= 4'h0;
         O_CKE_OE        <= 4'hF;
         O_CS_PD         <= 4'h0;
         O_CS_OE         <= 4'hF;
         O_CLK_OE        <= 4'hF;
         O_ODT_OE        <= 4'hF;
         O_WCK_OE        <= 4'h0;
         O_PRECHARGE_REQ <= 4'h0;
         O_CMD_OK        <= 4'h0;
         O_PAGES_CLOSED  <= 4'h0;
         O_LANE_MAP      <= 64'h0;
      end else begin
         // no cke pin on cs-based parts: power-down carried by chip select
         O_CKE    <= cs_based ? 4'h0 : cke_on;
         O_CS_PD  <= cs_based ? ~cke_on : 4'h0;
         O_CKE_OE <= cs_based ? 4'h0 : ~hi_z_d;
         O_CS_OE  <= ~hi_z_d;
         O_CLK_OE <= ~hi_z_d;
         O_ODT_OE <= ~hi_z_d;
         O_WCK_OE <= (tech == `TECH_LP5) ? ~hi_z_d : 4'h0;
         O_PRECHARGE_REQ <= pchg_req;
         O_CMD_OK        <= cmd_ok & ~txn_arrive_q;
         O_PAGES_CLOSED  <= pg_closed;
         O_LANE_MAP      <= lane_map_d;
      end
   end

endmodule // dram_rank_power_down_control

// ==== rtl/rank_pd_fsm.v ====
/*
 * one rank's idle counter and power-down sequencer.
 * assumes link_tick marks one dram clock edge, found by the parent.
 */
`timescale 1ns/1ps
`include "pd_ctrl_defs.vh"

module rank_pd_fsm (
   // clock and reset
   input  wire        clk,
   input  wire        rst,
   // configuration
   input  wire        cke_release,
   input  wire [3:0]  pd_type,
   input  wire [11:0] idle_timeout,
   // traffic
   input  wire        link_tick,
   input  wire        txn_arrive,
   input  wire        txn_queued,
   input  wire        refresh_req,
   input  wire        precharge_done,
   // results
   output reg         cke_on,
   output reg         powered_down,
   output reg         precharge_req,
   output reg         cmd_ok,
   output reg         pages_closed
);

   localparam [2:0] S_INIT  = 3'h0;
   localparam [2:0] S_AWAKE = 3'h1;
   localparam [2:0] S_PCHG  = 3'h2;
   localparam [2:0] S_DOWN  = 3'h3;
   localparam [2:0] S_EXIT  = 3'h4;

   reg [2:0]  state_q;
   reg [11:0] idle_q;
   reg [3:0]  exit_q;
   reg        refresh_wake_q;
   wire       expired = (idle_q >= idle_timeout);
   wire       want_pd = (pd_type == `PD_OPEN_PAGE) || (pd_type == `PD_CLOSED_PAGE);

   always @(posedge clk) begin
      if (rst) begin
         state_q        <= S_INIT;
         idle_q         <= 12'h000;
         exit_q         <= 4'h0;
         refresh_wake_q <= 1'b0;
         cke_on         <= 1'b0;
         powered_down   <= 1'b0;
         precharge_req  <= 1'b0;
         cmd_ok         <= 1'b0;
         pages_closed   <= 1'b0;
      end else begin
         // counter restarts on every arrival, otherwise counts dram clocks until it reaches the timeout
         if (txn_arrive)
            idle_q <= 12'h000;
         else if (link_tick && !expired)
            idle_q <= idle_q + 12'h001;
         case (state_q)
            S_INIT: begin
               cke_on <= 1'b0;
               if (cke_release) begin
                  state_q <= S_AWAKE;
                  cke_on  <= 1'b1;
                  cmd_ok  <= 1'b1;
               end
            end
            S_AWAKE: begin
               // zero timeout is eligible at once
               if (refresh_wake_q && !refresh_req) begin
                  refresh_wake_q <= 1'b0;
               end else if (want_pd && expired && !txn_queued && !txn_arrive
                            && !refresh_req) begin
                  cmd_ok <= 1'b0;
                  if (pd_type == `PD_CLOSED_PAGE) begin
                     state_q       <= S_PCHG;
                     precharge_req <= 1'b1;
                  end else begin
                     state_q      <= S_DOWN;
                     cke_on       <= 1'b0;
                     powered_down <= 1'b1;
                  end
               end
            end
            S_PCHG: begin
               if (txn_arrive || refresh_req) begin
                  state_q       <= S_AWAKE;
                  precharge_req <= 1'b0;
                  cmd_ok        <= 1'b1;
                  pages_closed  <= precharge_done;
               end else if (precharge_done) begin
                  state_q       <= S_DOWN;
                  precharge_req <= 1'b0;
                  cke_on        <= 1'b0;
                  powered_down  <= 1'b1;
                  pages_closed  <= 1'b1;
               end
            end
            S_DOWN: begin
               if (txn_arrive || txn_queued || refresh_req) begin
                  state_q        <= S_EXIT;
                  cke_on         <= 1'b1;
                  exit_q         <= 4'h0;
                  refresh_wake_q <= refresh_req;
               end
            end
            S_EXIT: begin
               if (link_tick) begin
                  if (exit_q == `EXIT_LAT_CYC - 4'h1) begin
                     state_q      <= S_AWAKE;
                     powered_down <= 1'b0;
                     cmd_ok       <= 1'b1;
                  end else begin
                     exit_q <= exit_q + 4'h1;
                  end
               end
            end
            default: state_q <= S_INIT;
         endcase
         // pages reopen once the scheduler issues to the rank again
         if (state_q == S_AWAKE && txn_arrive)
            pages_closed <= 1'b0;
      end
   end

endmodule // rank_pd_fsm

// ==== shared/pd_ctrl_defs.vh ====
/*
 * constants for the rank power-down controller: register map, field positions,
 * reset values, technology and power-down type codes, timing counts.
 * assumes a 200 MHz system clock and a 32-bit apb register bus.
 */
`ifndef PD_CTRL_DEFS_VH
`define PD_CTRL_DEFS_VH

// register byte addresses
`define ADDR_PDCFG        12'h000
`define ADDR_CTRL         12'h004
`define ADDR_POP          12'h008
`define ADDR_STATUS       12'h00C
`define ADDR_LANEMAP      12'h010

// dram_powerdown_config fields
`define PDCFG_TYPE_HI     15
`define PDCFG_TYPE_LO     12
`define PDCFG_IDLE_HI     11
`define PDCFG_IDLE_LO     0
`define PDCFG_RESET       16'h0000

// power_down_type_select codes
`define PD_NONE           4'h0
`define PD_OPEN_PAGE      4'h1
`define PD_CLOSED_PAGE    4'h2

// control register bits
`define CTRL_CKE_RELEASE  0
`define CTRL_LOCK         1
`define CTRL_INTERLEAVE   2
`define CTRL_TRISTATE_EN  3
`define CTRL_TECH_LO      4
`define CTRL_TECH_HI      5

// technology codes
`define TECH_DDR4         2'h0
`define TECH_DDR5         2'h1
`define TECH_LP4X         2'h2
`define TECH_LP5          2'h3

// exit latency in link clock cycles
`define EXIT_LAT_CYC      4'h4
// number of ranks, one power-down sequencer each
`define NUM_RANKS         4

`endif

// ==== tb/dram_side_model.sv ====
/* far-side dram model: free-running dram clock, precharge-all answer.
   assumes the controller holds a precharge request until answered. */
`timescale 1ns/1ps
module dram_side_model #(
   parameter int LAG = 2 // dram edges after the first before precharge completes, 0 to 3
) (
   output logic            o_dram_clk,
   input  wire logic [3:0] i_pre_req,
   output logic [3:0]      o_pre_done
);
   logic [15:0] pipe_q = 16'h0000;
   initial o_dram_clk = 1'h0;
   // phase unrelated to the system clock
   always #24 o_dram_clk = ~o_dram_clk;
   always @(posedge o_dram_clk) pipe_q <= {pipe_q[11:0], i_pre_req};
   // done drops with the request so a stale answer never lingers
   assign o_pre_done = pipe_q[4*LAG+3 -: 4] & i_pre_req;
endmodule // dram_side_model

// ==== tb/pd_ctrl_sva.sv ====
/* checker on the power-down controller ports.
   assumes ddr4 traffic whenever ranks are woken or put to sleep. */
`timescale 1ns/1ps
module pd_ctrl_sva (
   input wire logic        I_CLK, I_RST, I_PSEL, I_PENABLE, I_PWRITE,
   input wire logic        O_PREADY, O_PSLVERR, I_REFRESH_REQ,
   input wire logic [11:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [3:0]  I_TXN_ARRIVE, I_TXN_QUEUED, O_PRECHARGE_REQ,
   input wire logic [3:0]  O_CMD_OK, O_CKE, O_CKE_OE
);
   logic rel_q, tri_q;
   wire  ctl_wr = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY && I_PADDR == 12'h004;
   always @(posedge I_CLK)
      if (I_RST) begin
         rel_q <= 1'h0;
         tri_q <= 1'h0;
      end else if (ctl_wr) begin
         rel_q <= rel_q | I_PWDATA[0];
         tri_q <= tri_q | I_PWDATA[3];
      end
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   cke_held_a: assert property (!rel_q |-> O_CKE == 4'h0)
      else $error("cke before release");
   cke_oe_a: assert property (!tri_q |-> O_CKE_OE == 4'hF)
      else $error("cke undriven");
   ready_a: assert property (I_PSEL && !I_PENABLE |=> O_PREADY ##1 !O_PREADY)
      else $error("ready timing");
   slverr_a: assert property (O_PREADY |-> O_PSLVERR == (I_PADDR > 12'h010))
      else $error("slverr wrong");
   idle_hold_a: assert property (I_TXN_ARRIVE[0] && O_CKE[0] |=> O_CKE[0] [*2])
      else $error("cke fell on arrival");
   queued_a: assert property (I_TXN_QUEUED[0] && O_CKE[0] |=> O_CKE[0])
      else $error("cke fell while queued");
   exit_wait_a: assert property ($rose(O_CKE[0]) && $past(rel_q, 4) |-> !O_CMD_OK[0] [*8])
      else $error("command too soon after wake");
   pre_first_a: assert property (O_PRECHARGE_REQ[0] |-> O_CKE[0])
      else $error("cke fell before precharge");
   refresh_a: assert property ($rose(I_REFRESH_REQ) |-> ##[1:8] O_CKE == 4'hF)
      else $error("ranks not woken for refresh");
endmodule // pd_ctrl_sva
bind dram_rank_power_down_control pd_ctrl_sva pd_ctrl_sva_i (.I_CLK, .I_RST, .I_PSEL,
   .I_PENABLE, .I_PWRITE, .O_PREADY, .O_PSLVERR, .I_REFRESH_REQ, .I_PADDR, .I_PWDATA,
   .I_TXN_ARRIVE, .I_TXN_QUEUED, .O_PRECHARGE_REQ, .O_CMD_OK, .O_CKE, .O_CKE_OE);

// ==== tb/test_dram_rank_power_down_control.sv ====
/* self-checking bench for the rank power-down controller.
   assumes the dram model supplies the link clock and precharge answers. */
`timescale 1ns/1ps
module test_dram_rank_power_down_control;
   logic clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0, rfr = 1'h0;
   logic dram_clock_cycle, pready, pslverr;
   logic [11:0] padr = 12'h000;
   logic [31:0] pwd = 32'h0, prdata, rnd = 32'hE88F;
   logic [3:0] arr = 4'h0, qd = 4'h0, pdone, preq, cmdok, pcl, cke, ckeoe, csoe, clkoe;
   logic [3:0] odtoe, wckoe;
   logic [63:0] lmap;
   logic [32:0] q[$], ex;
   int err_total = 0, total_checks = 0, c;
   dram_rank_power_down_control dram_rank_power_down_control_i (.I_CLK(clk), .I_RST(rst),
      .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(padr), .I_PWDATA(pwd),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_DRAM_CLK(dram_clock_cycle),
      .I_TXN_ARRIVE(arr), .I_TXN_QUEUED(qd), .I_REFRESH_REQ(rfr), .I_PRECHARGE_DONE(pdone),
      .O_PRECHARGE_REQ(preq), .O_CMD_OK(cmdok), .O_PAGES_CLOSED(pcl), .O_LANE_MAP(lmap),
      .O_CKE(cke), .O_CKE_OE(ckeoe), .O_CS_PD(), .O_CS_OE(csoe), .O_CLK_OE(clkoe),
      .O_ODT_OE(odtoe), .O_WCK_OE(wckoe));
   dram_side_model dram_side_model_i (.o_dram_clk(dram_clock_cycle), .i_pre_req(preq), .o_pre_done(pdone));
   always #2.5 clk = ~clk;
   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input logic ok);
      total_checks++;
      if (ok !== 1'h1) begin
         err_total++;
         $display("ERROR %0t port value wrong", $time);
      end
   endtask
   task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1; pen <= 1'h0; pwr <= w; padr <= a; pwd <= d;
      @(posedge clk);
      pen <= 1'h1;
      // request stands until ready is seen high at a rising edge
      do @(posedge clk); while (pready !== 1'h1);
      psel <= 1'h0; pen <= 1'h0;
   endtask
   task rd(input logic [11:0] a, input logic [32:0] e);
      q.push_back(e);
      acc(1'h0, a, 32'h0);
   endtask
   task wt(input int k, input logic v);
      logic s;
      c = 0;
      do begin
         @(negedge clk);
         c++;
         s = k == 0 ? cke[0] : k == 1 ? cmdok[0] : preq[0];
      end while (s !== v && c < 500);
   endtask
   task hit(input logic [3:0] m, input logic [3:0] qv);
      @(posedge clk);
      arr <= m; qd <= qv;
      @(posedge clk);
      arr <= 4'h0;
   endtask
   task test_done;
      if (err_total == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // read answers are matched in order against the queued expectations
   always @(posedge clk)
      if (pready === 1'h1 && psel && pen && !pwr) begin
         ex = q.size() ? q.pop_front() : 33'h0;
         total_checks++;
         if (ex[32] ? pslverr !== 1'h1 : {pslverr, prdata} !== ex) begin
            err_total++;
            $display("ERROR %0t read mismatch at %h", $time, padr);
         end
      end
   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      test_done;
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'h0;
      @(negedge clk); chk(cke === 4'h0 && ckeoe === 4'hF && wckoe === 4'h0);
      rd(12'h000, 33'h0);
      rd(12'h008, 33'hF);
      rd(12'h040, 33'h1_0000_0000);
      acc(1'h1, 12'h004, 32'h4);
      repeat (3) @(negedge clk); chk(lmap === 64'hFEBA7632DC985410);
      acc(1'h1, 12'h004, 32'h0);
      repeat (3) @(negedge clk); chk(lmap === 64'hFEDCBA9876543210 && cke === 4'h0);
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr(rnd);
         acc(1'h1, 12'h000, rnd);
         rd(12'h000, {17'h0, rnd[15:0]});
      end
      acc(1'h1, 12'h000, 32'h1003);
      acc(1'h1, 12'h004, 32'h1);
      wt(0, 1'h1); chk(c < 8 && cke === 4'hF);
      hit(4'hF, 4'h0); wt(0, 1'h0); chk(c > 15 && c < 60 && pcl[0] === 1'h0);
      hit(4'h1, 4'h1); wt(0, 1'h1); chk(c < 8);
      wt(1, 1'h1); chk(c > 20 && c < 80);
      acc(1'h1, 12'h000, 32'h0);
      hit(4'hF, 4'h0); repeat (100) @(negedge clk); chk(cke === 4'hF);
      acc(1'h1, 12'h000, 32'h1000); wt(0, 1'h0); chk(c < 20);
      acc(1'h1, 12'h000, 32'h2002);
      hit(4'hF, 4'h0); wt(2, 1'h1); chk(c < 60 && cke[0] === 1'h1);
      wt(0, 1'h0); chk(c < 60);
      hit(4'h1, 4'h0); wt(0, 1'h1); chk(pcl[0] === 1'h1);
      wt(0, 1'h0);
      @(posedge clk); rfr <= 1'h1;
      repeat (12) @(negedge clk); chk(cke === 4'hF);
      @(posedge clk); rfr <= 1'h0;
      wt(0, 1'h0); chk(c < 80);
      acc(1'h1, 12'h000, 32'h5);
      acc(1'h1, 12'h004, 32'h3);
      acc(1'h1, 12'h000, 32'h1ABC);
      rd(12'h000, 33'h5);
      acc(1'h1, 12'h008, 32'hE);
      repeat (3) @(negedge clk); chk(ckeoe === 4'hF);
      acc(1'h1, 12'h004, 32'hB);
      repeat (3) @(negedge clk); chk({ckeoe, clkoe, odtoe, csoe} === 16'hEEEE);
      acc(1'h1, 12'h004, 32'h1B);
      repeat (3) @(negedge clk); chk(cke === 4'h0 && wckoe === 4'h0);
      acc(1'h1, 12'h004, 32'h3B);
      repeat (3) @(negedge clk); chk(cke === 4'h0 && wckoe === 4'hE);
      test_done;
   end
endmodule // test_dram_rank_power_down_control
